// *** hw/daem_pkg.sv ***
// daem_pkg: constants and carrier types for the alarm and event manager
// assumes a 50 MHz ref_clk and a seconds time base derived from it
package daem_pkg;
    // timing
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned REFRESH_S     = 1;      // live refresh period, s
    localparam int unsigned HOLDOFF_MIN   = 5;      // ack/download hold-off, min
    localparam int unsigned HOLDOFF_S     = HOLDOFF_MIN * 60;
    localparam int unsigned CAPTURE_MIN   = 10;     // capture window, min
    localparam int unsigned CAPTURE_S     = CAPTURE_MIN * 60;
    localparam int unsigned CAPTURE_PRE_S = CAPTURE_S / 2;
    localparam int unsigned TICK_CYCLES   = CLK_HZ * REFRESH_S;
    // sizes
    localparam int unsigned N_CAT         = 3;      // event categories
    localparam int unsigned N_TYPE        = 8;      // warning types
    localparam int unsigned HIST_DEPTH    = 16;     // acked records per cat
    localparam int unsigned N_PARAM       = 8;      // live parameters
    localparam int unsigned PARAM_W       = 16;
    localparam int unsigned TS_W          = 32;
    localparam int unsigned CMT_W         = 32;
    localparam int unsigned HIDX_W        = 4;
    localparam int unsigned TYPE_W        = 3;
    localparam int unsigned CAT_W         = 2;
    // category codes
    localparam logic [CAT_W-1:0] CAT_USER = 2'h0;
    localparam logic [CAT_W-1:0] CAT_MFR  = 2'h1;
    localparam logic [CAT_W-1:0] CAT_SYS  = 2'h2;

    // one stored event record
    typedef struct packed {
        logic [CAT_W-1:0]  cat;
        logic [TYPE_W-1:0] wtype;
        logic [TS_W-1:0]   t_event;
        logic [TS_W-1:0]   t_ack;
        logic [CMT_W-1:0]  comment;
    } daem_rec_t;

    // acknowledgement request from the wireless side
    typedef struct packed {
        logic [TYPE_W-1:0] wtype;
        logic [CMT_W-1:0]  comment;
    } daem_ack_t;

    // acknowledgement result codes
    typedef enum logic [1:0] {
        DAEM_ACK_OK      = 2'h0,
        DAEM_ACK_EARLY   = 2'h1,
        DAEM_ACK_NOEVENT = 2'h2,
        DAEM_ACK_NOLINK  = 2'h3
    } daem_ackres_t;
endpackage : daem_pkg

// *** hw/daem_core.sv ***
// daem_core: alarm and event manager of the encoder diagnostics
// assumes sensor values, raise requests and link requests synchronous
//
// Notes on behaviour
// - refresh all live parameters once per second
// - keep sixteen acked records per category
// - refuse ack and download before five minutes
// - capture ten-minute window centred on event
// - ack of last active warning returns status to normal
// - no repeat warning while same type unacked
// - other warning types still raised meanwhile
// - after ack, same type may recur
// - link lamp while connected; one peer only
// - lifetime record flags active or acknowledged
// - store acknowledgement comment with event
`timescale 1ns/100ps
`default_nettype none
module daem_core #(
    parameter int unsigned TICK_CYCLES = daem_pkg::TICK_CYCLES,
    parameter int unsigned HOLDOFF_S   = daem_pkg::HOLDOFF_S
) (
    // clock and reset
    input  wire logic                                 ref_clk,
    input  wire logic                                 rst_n,
    // live sensor readings
    input  wire logic [daem_pkg::N_PARAM*daem_pkg::PARAM_W-1:0] sensor_in,
    output logic [daem_pkg::N_PARAM*daem_pkg::PARAM_W-1:0]      live_out,
    output logic                                      live_upd,
    // warning sources, one bit per type, and a two-bit category code per type
    input  wire logic [daem_pkg::N_TYPE-1:0]          raise_req,
    input  wire logic [daem_pkg::N_TYPE*daem_pkg::CAT_W-1:0] type_cat,
    // wireless link
    input  wire logic                                 link_req,
    input  wire logic                                 link_drop,
    output logic                                      link_lamp,
    output logic                                      link_busy_refuse,
    // acknowledgement
    input  wire logic                                 ack_valid,
    input  wire daem_pkg::daem_ack_t                  ack_in,
    output logic                                      ack_done,
    output daem_pkg::daem_ackres_t                    ack_res,
    // event data download permission
    input  wire logic                                 dl_req,
    input  wire logic [daem_pkg::TYPE_W-1:0]          dl_type,
    output logic                                      dl_grant,
    output logic                                      dl_refuse,
    output logic [daem_pkg::TS_W-1:0]                 cap_start,
    output logic [daem_pkg::TS_W-1:0]                 cap_end,
    // status and lifetime record
    output logic                                      status_warn,
    output logic [daem_pkg::N_TYPE-1:0]               active_flags,
    output logic [daem_pkg::TS_W-1:0]                 now_s,
    // history readout
    input  wire logic [daem_pkg::CAT_W-1:0]           hist_cat,
    input  wire logic [daem_pkg::HIDX_W-1:0]          hist_idx,
    output daem_pkg::daem_rec_t                       hist_rec,
    output logic [daem_pkg::HIDX_W:0]                 hist_count
);
    localparam int unsigned NT = daem_pkg::N_TYPE;
    localparam int unsigned TW = daem_pkg::TS_W;
    localparam int unsigned HD = daem_pkg::HIST_DEPTH;

    // seconds divider and free-running seconds counter
    logic [31:0]   div_q, div_d;
    logic          tick_q, tick_d;
    logic [TW-1:0] sec_q, sec_d;
    always_comb begin
        div_d  = div_q + 32'h1;
        tick_d = 1'b0;
        sec_d  = sec_q;
        if (div_q == 32'(TICK_CYCLES - 1)) begin
            div_d  = 32'h0;
            tick_d = 1'b1;
            sec_d  = sec_q + 32'h1;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= 32'h0;
            tick_q <= 1'b0;
            sec_q  <= 32'h0;
        end else begin
            div_q  <= div_d;
            tick_q <= tick_d;
            sec_q  <= sec_d;
        end
    end

    // live parameter snapshot once per second
    logic [daem_pkg::N_PARAM*daem_pkg::PARAM_W-1:0] live_q, live_d;
    logic upd_q, upd_d;
    always_comb begin
        live_d = tick_q ? sensor_in : live_q;
        upd_d  = tick_q;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_q <= '0;
            upd_q  <= 1'b0;
        end else begin
            live_q <= live_d;
            upd_q  <= upd_d;
        end
    end

    // link ownership: one peer at a time
    logic lamp_q, lamp_d, refuse_q, refuse_d;
    always_comb begin
        lamp_d   = lamp_q;
        refuse_d = 1'b0;
        if (link_drop) begin
            lamp_d = 1'b0;
        end else if (link_req) begin
            if (lamp_q) begin
                refuse_d = 1'b1;
            end else begin
                lamp_d = 1'b1;
            end
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lamp_q   <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            lamp_q   <= lamp_d;
            refuse_q <= refuse_d;
        end
    end

    // per-type active flags and event timestamps
    logic [NT-1:0] act_q, act_d;
    logic [TW-1:0] ts_q [NT];
    logic [TW-1:0] ts_d [NT];
    logic          ack_hit;
    logic [daem_pkg::TYPE_W-1:0] at;
    logic          ack_ripe;
    assign at       = ack_in.wtype;
    assign ack_ripe = (sec_q - ts_q[at]) >= TW'(HOLDOFF_S);
    assign ack_hit  = ack_valid && lamp_q && act_q[at] && ack_ripe;

    genvar g;
    generate
        for (g = 0; g < NT; g++) begin : g_type
            always_comb begin
                act_d[g] = act_q[g];
                ts_d[g]  = ts_q[g];
                if (ack_hit && at == g) begin
                    act_d[g] = 1'b0;
                end
                // a raise wins over an ack in the same cycle; types independent
                if (raise_req[g] && !act_d[g]) begin
                    act_d[g] = 1'b1;
                    ts_d[g]  = sec_q;
                end
            end
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    act_q[g] <= 1'b0;
                    ts_q[g]  <= '0;
                end else begin
                    act_q[g] <= act_d[g];
                    ts_q[g]  <= ts_d[g];
                end
            end
        end
    endgenerate

    // acknowledged history, sixteen-deep ring per category
    daem_pkg::daem_rec_t hist_mem [daem_pkg::N_CAT][HD];
    logic [daem_pkg::HIDX_W-1:0] wp_q [daem_pkg::N_CAT];
    logic [daem_pkg::HIDX_W:0]   cnt_q [daem_pkg::N_CAT];
    logic [daem_pkg::CAT_W-1:0]  acat;
    daem_pkg::daem_rec_t         new_rec;
    logic                        store_ok;
    assign acat = type_cat[at*daem_pkg::CAT_W +: daem_pkg::CAT_W];
    // an unused category code is acked but leaves no record
    assign store_ok = ack_hit && (acat <= daem_pkg::CAT_SYS);
    always_comb begin
        new_rec.cat     = acat;
        new_rec.wtype   = at;
        new_rec.t_event = ts_q[at];
        new_rec.t_ack   = sec_q;
        new_rec.comment = ack_in.comment;
    end
    always_ff @(posedge ref_clk) begin
        if (store_ok) begin
            hist_mem[acat][wp_q[acat]] <= new_rec;
        end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int c = 0; c < daem_pkg::N_CAT; c++) begin
                wp_q[c]  <= '0;
                cnt_q[c] <= '0;
            end
        end else if (store_ok) begin
            wp_q[acat] <= wp_q[acat] + 4'h1; // oldest overwritten
            if (cnt_q[acat] != 5'(HD)) begin
                cnt_q[acat] <= cnt_q[acat] + 5'h1;
            end
        end
    end

    // registered outputs: ack answer, download, status, readout
    logic dn_q, dn_d, gr_q, gr_d, rf_q, rf_d, warn_q, warn_d;
    daem_pkg::daem_ackres_t res_q, res_d;
    logic [TW-1:0] cs_q, cs_d, ce_q, ce_d;
    logic dl_ripe;
    assign dl_ripe = (sec_q - ts_q[dl_type]) >= TW'(HOLDOFF_S);
    always_comb begin
        dn_d   = ack_valid;
        res_d  = daem_pkg::DAEM_ACK_OK;
        if (!lamp_q)         res_d = daem_pkg::DAEM_ACK_NOLINK;
        else if (!act_q[at]) res_d = daem_pkg::DAEM_ACK_NOEVENT;
        else if (!ack_ripe)  res_d = daem_pkg::DAEM_ACK_EARLY;
        gr_d   = dl_req && lamp_q && dl_ripe;
        rf_d   = dl_req && !(lamp_q && dl_ripe);
        cs_d   = gr_d ? ts_q[dl_type] - TW'(daem_pkg::CAPTURE_PRE_S) : cs_q;
        ce_d   = gr_d ? ts_q[dl_type] + TW'(daem_pkg::CAPTURE_PRE_S) : ce_q;
        // capture spans event time minus and plus half window
        warn_d = |act_d; // cleared once all warnings acked
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dn_q   <= 1'b0;
            res_q  <= daem_pkg::DAEM_ACK_OK;
            gr_q   <= 1'b0;
            rf_q   <= 1'b0;
            cs_q   <= '0;
            ce_q   <= '0;
            warn_q <= 1'b0;
        end else begin
            dn_q   <= dn_d;
            res_q  <= res_d;
            gr_q   <= gr_d;
            rf_q   <= rf_d;
            cs_q   <= cs_d;
            ce_q   <= ce_d;
            warn_q <= warn_d;
        end
    end

    // history readout, registered
    daem_pkg::daem_rec_t hrec_q;
    logic [daem_pkg::HIDX_W:0] hcnt_q;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrec_q <= '0;
            hcnt_q <= '0;
        end else if (hist_cat <= daem_pkg::CAT_SYS) begin
            hrec_q <= hist_mem[hist_cat][hist_idx];
            hcnt_q <= cnt_q[hist_cat];
        end else begin
            hrec_q <= '0;
            hcnt_q <= '0;
        end
    end

    assign live_out         = live_q;
    assign live_upd         = upd_q;
    assign link_lamp        = lamp_q;
    assign link_busy_refuse = refuse_q;
    assign ack_done         = dn_q;
    assign ack_res          = res_q;
    assign dl_grant         = gr_q;
    assign dl_refuse        = rf_q;
    assign cap_start        = cs_q;
    assign cap_end          = ce_q;
    assign status_warn      = warn_q;
    assign active_flags     = act_q;
    assign now_s            = sec_q;
    assign hist_rec         = hrec_q;
    assign hist_count       = hcnt_q;
endmodule : daem_core
`default_nettype wire

// *** test/daem_core_sva.sv ***
// daem_core_sva: port checker for the alarm and event manager
// assumes one clock domain and the bench's short tick and hold-off
`timescale 1ns/100ps
`default_nettype none
module daem_core_sva #(
    parameter int unsigned TICK_CYCLES = 10,
    parameter int unsigned HOLDOFF_S   = 3
) (
    // clock and reset
    input wire logic                  ref_clk,
    input wire logic                  rst_n,
    // watched ports
    input wire logic                  live_upd,
    input wire logic [7:0]            raise_req,
    input wire logic                  link_req,
    input wire logic                  link_drop,
    input wire logic                  link_lamp,
    input wire logic                  link_busy_refuse,
    input wire logic                  ack_valid,
    input wire daem_pkg::daem_ack_t   ack_in,
    input wire logic                  ack_done,
    input wire daem_pkg::daem_ackres_t ack_res,
    input wire logic                  dl_req,
    input wire logic                  dl_grant,
    input wire logic                  dl_refuse,
    input wire logic [31:0]           cap_start,
    input wire logic [31:0]           cap_end,
    input wire logic                  status_warn,
    input wire logic [7:0]            active_flags,
    input wire logic [31:0]           now_s
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // refresh pulses are at least nine cycles apart
    property p_upd; live_upd |=> !live_upd [*8]; endproperty
    a_upd: assert property (p_upd)
        else $error("refresh pulses too close");
    // status normal only when no type is active
    property p_stat; status_warn == (|active_flags); endproperty
    a_stat: assert property (p_stat)
        else $error("status does not follow active types");
    // every raised type becomes active on the next cycle
    property p_raise;
        |raise_req |=> (active_flags & $past(raise_req)) == $past(raise_req);
    endproperty
    a_raise: assert property (p_raise)
        else $error("raised type not active");
    // a good ack clears its type
    property p_ack;
        ack_valid && !(|raise_req) |=> ack_done &&
            (ack_res != daem_pkg::DAEM_ACK_OK ||
             !active_flags[$past(ack_in.wtype)]);
    endproperty
    a_ack: assert property (p_ack)
        else $error("ack result or clear wrong");
    // ack without a link is refused as such
    property p_nolink;
        ack_valid && !link_lamp && !link_req |=>
            ack_res == daem_pkg::DAEM_ACK_NOLINK;
    endproperty
    a_nolink: assert property (p_nolink)
        else $error("ack without link not refused");
    // connect lights the lamp, drop puts it out
    property p_lamp; link_req && !link_drop |=> link_lamp; endproperty
    a_lamp: assert property (p_lamp)
        else $error("lamp not lit on connect");
    property p_drop; link_drop |=> !link_lamp; endproperty
    a_drop: assert property (p_drop)
        else $error("lamp still lit after drop");
    // a second peer is refused only while connected
    property p_busy;
        link_busy_refuse |-> $past(link_req) && $past(link_lamp);
    endproperty
    a_busy: assert property (p_busy)
        else $error("spurious busy refusal");
    // download request gets exactly one answer
    property p_dl; dl_req |=> dl_grant != dl_refuse; endproperty
    a_dl: assert property (p_dl)
        else $error("download answer missing");
    // granted capture spans 600 s around an event at least hold-off old
    property p_cap;
        dl_grant |-> cap_end - cap_start == 32'h258 && $past(link_lamp) &&
            ($past(now_s) - cap_start) >= 32'(HOLDOFF_S) + 32'h12c;
    endproperty
    a_cap: assert property (p_cap)
        else $error("capture span wrong");
    // seconds counter only steps by one
    property p_now; now_s != $past(now_s) |-> now_s == $past(now_s) + 32'h1;
    endproperty
    a_now: assert property (p_now)
        else $error("seconds counter jumped");
endmodule : daem_core_sva
bind daem_core daem_core_sva #(.TICK_CYCLES(TICK_CYCLES),
    .HOLDOFF_S(HOLDOFF_S)) u_sva (.ref_clk(ref_clk), .rst_n(rst_n),
    .live_upd(live_upd), .raise_req(raise_req), .link_req(link_req),
    .link_drop(link_drop), .link_lamp(link_lamp),
    .link_busy_refuse(link_busy_refuse), .ack_valid(ack_valid),
    .ack_in(ack_in), .ack_done(ack_done), .ack_res(ack_res),
    .dl_req(dl_req), .dl_grant(dl_grant), .dl_refuse(dl_refuse),
    .cap_start(cap_start), .cap_end(cap_end), .status_warn(status_warn),
    .active_flags(active_flags), .now_s(now_s));
`default_nettype wire

// *** test/daem_peer.sv ***
// daem_peer: behavioural wireless peer issuing link, ack and download
// assumes requests are sampled on the rising edge of ref_clk
`timescale 1ns/100ps
`default_nettype none
module daem_peer #(
    parameter int unsigned BOOT_CYC = 20
) (
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    // requests towards the device
    output var logic                  link_req,
    output var logic                  link_drop,
    output var logic                  ack_valid,
    output var daem_pkg::daem_ack_t   ack_in,
    output var logic                  dl_req,
    output var logic [2:0]            dl_type
);
    int up_cnt;
    // cycles since power-up, for the boot wait
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) up_cnt <= 0;
        else if (up_cnt < BOOT_CYC) up_cnt <= up_cnt + 1;
    end
    initial begin
        {link_req, link_drop, ack_valid, dl_req} = 4'h0;
        ack_in = '0;
        dl_type = 3'h0;
    end
    // connect only once the device has booted
    task automatic connect();
        wait (up_cnt == BOOT_CYC);
        @(negedge ref_clk) link_req = 1'b1;
        @(negedge ref_clk) link_req = 1'b0;
    endtask : connect
    task automatic drop();
        @(negedge ref_clk) link_drop = 1'b1;
        @(negedge ref_clk) link_drop = 1'b0;
    endtask : drop
    // ack with a comment; idle data is inverted after release
    task automatic ack(input logic [2:0] t, input logic [31:0] c);
        @(negedge ref_clk) ack_valid = 1'b1;
        ack_in = '{wtype: t, comment: c};
        @(negedge ref_clk) ack_valid = 1'b0;
        ack_in = ~ack_in;
    endtask : ack
    task automatic dl(input logic [2:0] t);
        @(negedge ref_clk) dl_req = 1'b1;
        dl_type = t;
        @(negedge ref_clk) dl_req = 1'b0;
        dl_type = ~t;
    endtask : dl
endmodule : daem_peer
`default_nettype wire

// *** test/daem_core_tb.sv ***
// daem_core_tb: self-checking bench for the alarm and event manager
// assumes short tick (10 cycles a second) and a 3 s hold-off
`timescale 1ns/100ps
`default_nettype none
module daem_core_tb;
    logic ref_clk, rst_n, live_upd, link_req, link_drop, link_lamp, busy;
    logic ack_valid, ack_done, dl_req, dl_grant, dl_refuse, status_warn;
    logic [127:0] sensor_in, live_out;
    logic [7:0] raise_req, active_flags;
    logic [15:0] type_cat;
    logic [31:0] cap_start, cap_end, now_s, cmt, t_last, t2;
    logic [2:0] dl_type;
    logic [1:0] hist_cat;
    logic [3:0] hist_idx;
    logic [4:0] hist_count;
    daem_pkg::daem_ack_t ack_in;
    daem_pkg::daem_ackres_t ack_res;
    daem_pkg::daem_rec_t hist_rec;
    daem_pkg::daem_ackres_t aq[$];
    logic dq[$];
    int num_errors, n_checks, cyc, n_upd, n_busy;
    daem_core #(.TICK_CYCLES(10), .HOLDOFF_S(3)) DUT (.ref_clk(ref_clk),
        .rst_n(rst_n), .sensor_in(sensor_in), .live_out(live_out),
        .live_upd(live_upd), .raise_req(raise_req), .type_cat(type_cat),
        .link_req(link_req), .link_drop(link_drop), .link_lamp(link_lamp),
        .link_busy_refuse(busy), .ack_valid(ack_valid), .ack_in(ack_in),
        .ack_done(ack_done), .ack_res(ack_res), .dl_req(dl_req),
        .dl_type(dl_type), .dl_grant(dl_grant), .dl_refuse(dl_refuse),
        .cap_start(cap_start), .cap_end(cap_end), .status_warn(status_warn),
        .active_flags(active_flags), .now_s(now_s), .hist_cat(hist_cat),
        .hist_idx(hist_idx), .hist_rec(hist_rec), .hist_count(hist_count));
    daem_peer peer (.ref_clk(ref_clk), .rst_n(rst_n), .link_req(link_req),
        .link_drop(link_drop), .ack_valid(ack_valid), .ack_in(ack_in),
        .dl_req(dl_req), .dl_type(dl_type));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic raise(input int t);
        @(negedge ref_clk) raise_req[t] = 1'b1;
        t_last = now_s;
        @(negedge ref_clk) raise_req[t] = 1'b0;
    endtask : raise
    task automatic secs(input int n);
        repeat (n * 10) @(negedge ref_clk);
    endtask : secs
    task automatic ack(input logic [2:0] t, input daem_pkg::daem_ackres_t r);
        cmt = $urandom;
        aq.push_back(r);
        peer.ack(t, cmt);
    endtask : ack
    // result monitor: compare answers against the oldest note
    always @(posedge ref_clk) begin
        #1;
        if (ack_done === 1'b1) chk(ack_res, aq.pop_front());
        if (dl_grant === 1'b1 || dl_refuse === 1'b1)
            chk(dl_grant, dq.pop_front());
        if (busy === 1'b1) n_busy++;
        if (live_upd === 1'b1) n_upd++;
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        {rst_n, raise_req, hist_cat, hist_idx} = '0;
        {num_errors, n_checks, cyc, n_upd, n_busy} = '0;
        type_cat = 16'h0800;
        void'($urandom(32'h3a7a4ddd));
        sensor_in = {$urandom, $urandom, $urandom, $urandom};
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        ack(3'h2, daem_pkg::DAEM_ACK_NOLINK);
        dq.push_back(1'b0);
        peer.dl(3'h2);
        peer.connect();
        peer.connect();
        chk(link_lamp, 1'b1);
        chk(n_busy, 1);
        raise(2);
        t2 = t_last;
        raise(5);
        chk(active_flags, 8'h24);
        ack(3'h5, daem_pkg::DAEM_ACK_EARLY);
        dq.push_back(1'b0);
        peer.dl(3'h5);
        ack(3'h3, daem_pkg::DAEM_ACK_NOEVENT);
        secs(2);
        raise(2);
        secs(2);
        dq.push_back(1'b1);
        peer.dl(3'h2);
        chk(cap_start, t2 - 32'h12c);
        chk(cap_end, t2 + 32'h12c);
        ack(3'h2, daem_pkg::DAEM_ACK_OK);
        chk(active_flags, 8'h20);
        @(negedge ref_clk);
        @(negedge ref_clk);
        chk(hist_rec.comment, cmt);
        chk(hist_rec.wtype, 3'h2);
        chk(hist_rec.t_event, t2);
        ack(3'h5, daem_pkg::DAEM_ACK_OK);
        chk(status_warn, 1'b0);
        for (int i = 0; i < 16; i++) begin
            raise(2);
            chk(active_flags[2], 1'b1);
            secs(4);
            ack(3'h2, daem_pkg::DAEM_ACK_OK);
        end
        @(negedge ref_clk);
        chk(hist_count, 5'h10);
        hist_idx = 4'h5;
        @(negedge ref_clk);
        chk(hist_rec.wtype, 3'h2);
        chk(hist_rec.cat, daem_pkg::CAT_USER);
        hist_cat = daem_pkg::CAT_SYS;
        hist_idx = 4'h0;
        @(negedge ref_clk);
        chk(hist_count, 5'h1);
        chk(hist_rec.wtype, 3'h5);
        hist_cat = 2'h3;
        @(negedge ref_clk);
        chk(hist_count, 5'h0);
        hist_cat = daem_pkg::CAT_USER;
        // raise and ack of one type on the same edge: the raise wins
        raise(2);
        secs(4);
        fork
            raise(2);
            ack(3'h2, daem_pkg::DAEM_ACK_OK);
        join
        chk(active_flags[2], 1'b1);
        sensor_in = {$urandom, $urandom, $urandom, $urandom};
        n_upd = 0;
        secs(10);
        chk(n_upd, 10);
        for (int w = 0; w < 4; w++) begin
            chk(live_out[w*32 +: 32], sensor_in[w*32 +: 32]);
        end
        peer.drop();
        chk(link_lamp, 1'b0);
        end_of_test();
    end
endmodule : daem_core_tb
`default_nettype wire
